// File: shared/pulse_counter_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the pulse counter.
 Assumes a 200 MHz system clock and a 32-bit Wishbone register bus.
*/
`ifndef PULSE_COUNTER_DEFS_SVH
`define PULSE_COUNTER_DEFS_SVH

`define PC_NUM_CH 4
`define PC_CLK_HZ 200000000
// Register byte offsets, channel block stride 0x20 from 0x40
`define PC_OFF_CLEAR 8'h00
`define PC_OFF_STATUS 8'h04
`define PC_OFF_IRQ_CLR 8'h08
`define PC_OFF_IRQ_EN 8'h0c
`define PC_OFF_LEVELS 8'h10
`define PC_OFF_CH_BASE 8'h40
`define PC_CH_STRIDE_LOG2 5
`define PC_OFF_CH_CTRL 5'h00
`define PC_OFF_CH_COUNT 5'h04
`define PC_OFF_CH_LOW 5'h08
`define PC_OFF_CH_HIGH 5'h0c
// Channel control fields
`define PC_CTRL_MODE_LSB 0
`define PC_CTRL_PROG_LSB 2
`define PC_CTRL_RST_LSB 4
`define PC_CTRL_SRC_LSB 6
`define PC_CTRL_FILT_LSB 8
`define PC_CTRL_RESET 32'h0000_0000
`define PC_LOW_RESET 32'h0000_0000
`define PC_HIGH_RESET 32'h7fff_ffff
// Filter: setting 1..9 selects 10..90 Hz, reject below half period
`define PC_FILT_STEP_HZ 10
`define PC_FILT_MAX_SEL 4'h9
`define PC_FILT_CNT_W 24

`endif

// File: shared/pulse_counter_pkg.sv
/*
 Types of the pulse counter: counting modes, control input modes, clear modes.
 Assumes nothing beyond the defines header for numbers.
*/
package pulse_counter_pkg;
  typedef enum logic [1:0] {
    MODE_SUM = 2'h0,
    MODE_DIFF = 2'h1,
    MODE_QUAD1 = 2'h2,
    MODE_QUAD4 = 2'h3
  } count_mode_t;
  typedef enum logic [1:0] {
    PROG_OFF = 2'h0,
    PROG_DIR = 2'h1,
    PROG_INHIBIT = 2'h2
  } prog_mode_t;
  typedef enum logic [1:0] {
    CLR_NONE = 2'h0,
    CLR_CHANNEL = 2'h1,
    CLR_EXT = 2'h2,
    CLR_BOTH = 2'h3
  } clr_mode_t;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_GAP = 3'b100
  } bus_state_t;
endpackage

// File: logic/pulse_counter.sv
/*
 Four-channel universal pulse counter with Wishbone classic register slave,
 debounce filters, clear sources, limit flags and a level interrupt.
 Assumes field inputs arrive asynchronously and pass the two-stage synchroniser.
*/
// Local design decisions: register access over Wishbone and the address map.
// Operation
// - four independent channels, two inputs, control, clear
// - sum mode counts rising edges of both
// - difference mode: input 1 up, 2 down
// - single encoder: edge on 1, 2 gives direction
// - fourfold encoder: rising edges of both, opposite input direction
// - software manual clear zeroes count at once
// - extra clear: none, channel, external, or both
// - channel clear while selected count above zero
// - disabled control input is ignored entirely
// - direction control swaps inputs in difference mode
// - direction control reverses encoder counting
// - inhibit control holds count while active
// - filter off or 10 to 90, rejects bounce
// - under-limit flag when count below low limit
// - over-limit flag when count above high limit
`timescale 1ns/100ps
`include "pulse_counter_defs.svh"

module pulse_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [3:0] count_a_i,
  input wire logic [3:0] count_b_i,
  input wire logic [3:0] prog_i,
  input wire logic [3:0] ext_clear_i,
  output logic [3:0] under_limit_flag_o,
  output logic [3:0] over_limit_flag_o,
  output logic irq_o
);
  import pulse_counter_pkg::*;

  localparam int NCH = `PC_NUM_CH;
  localparam int FW = `PC_FILT_CNT_W;

  // Half period of the filter frequency in clock cycles
  function automatic logic [FW-1:0] filt_len(input logic [3:0] s);
    int unsigned hz;
    hz = 32'(s) * `PC_FILT_STEP_HZ;
    filt_len = (s == 4'h0) ? '0 : FW'(`PC_CLK_HZ / (2 * hz));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic [31:0] ctrl_r [NCH];
  logic [31:0] count_r [NCH];
  logic [31:0] low_r [NCH];
  logic [31:0] high_r [NCH];
  logic [7:0] irq_en_r;
  logic [7:0] status_r;
  logic [3:0] sw_clear_r;
  bus_state_t bus_r;

  // Synchronisers and filters: 4 signals per channel
  logic [15:0] raw;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [15:0] filt_r;
  logic [15:0] filt_prev_r;
  logic [FW-1:0] stab_r [16];

  assign raw = {ext_clear_i, prog_i, count_b_i, count_a_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  // Level accepted only after holding stable for the filter length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_r <= 16'h0000;
      filt_prev_r <= 16'h0000;
      for (int k = 0; k < 16; k++) begin
        stab_r[k] <= '0;
      end
    end else begin
      filt_prev_r <= filt_r;
      for (int k = 0; k < 16; k++) begin
        if (sync2_r[k] == filt_r[k]) begin
          stab_r[k] <= '0;
        end else if (stab_r[k] >=
                     filt_len(ctrl_r[k % NCH][`PC_CTRL_FILT_LSB +: 4])) begin
          filt_r[k] <= sync2_r[k];
          stab_r[k] <= '0;
        end else begin
          stab_r[k] <= stab_r[k] + 1'b1;
        end
      end
    end
  end

  // One signed step for an encoder edge; the level gives the direction
  function automatic logic signed [2:0] enc_step(input logic hit, input logic up);
    if (!hit) begin
      enc_step = 3'sd0;
    end else if (up) begin
      enc_step = 3'sd1;
    end else begin
      enc_step = -3'sd1;
    end
  endfunction

  // Per channel view of the filtered inputs
  logic [3:0] lvl_a;
  logic [3:0] lvl_b;
  logic [3:0] rise_a;
  logic [3:0] rise_b;
  logic [3:0] prog_lvl;
  logic [3:0] ext_lvl;
  assign lvl_a = filt_r[3:0];
  assign lvl_b = filt_r[7:4];
  assign rise_a = filt_r[3:0] & ~filt_prev_r[3:0];
  assign rise_b = filt_r[7:4] & ~filt_prev_r[7:4];
  assign prog_lvl = filt_r[11:8];
  assign ext_lvl = filt_r[15:12];

  // Clear sources
  logic [3:0] clear_now;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      clr_mode_t cm;
      logic [1:0] src;
      logic src_pos;
      cm = clr_mode_t'(ctrl_r[c][`PC_CTRL_RST_LSB +: 2]);
      src = ctrl_r[c][`PC_CTRL_SRC_LSB +: 2];
      src_pos = $signed(count_r[src]) > 0;
      clear_now[c] = sw_clear_r[c]
        | (((cm == CLR_CHANNEL) | (cm == CLR_BOTH)) & src_pos)
        | (((cm == CLR_EXT) | (cm == CLR_BOTH)) & ext_lvl[c]);
    end
  end

  // Signed step per channel, from mode and control input
  logic signed [2:0] step [NCH];
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      count_mode_t md;
      prog_mode_t pm;
      logic pg;
      logic swp;
      md = count_mode_t'(ctrl_r[c][`PC_CTRL_MODE_LSB +: 2]);
      pm = prog_mode_t'(ctrl_r[c][`PC_CTRL_PROG_LSB +: 2]);
      pg = (pm != PROG_OFF) & prog_lvl[c];
      swp = (pm == PROG_DIR) & pg;
      step[c] = 3'sd0;
      unique case (md)
        MODE_SUM: begin
          step[c] = 3'(rise_a[c]) + 3'(rise_b[c]);
        end
        MODE_DIFF: begin
          if (swp) begin
            step[c] = 3'(rise_b[c]) - 3'(rise_a[c]);
          end else begin
            step[c] = 3'(rise_a[c]) - 3'(rise_b[c]);
          end
        end
        MODE_QUAD1: begin
          step[c] = enc_step(rise_a[c], lvl_b[c] ^ swp);
        end
        MODE_QUAD4: begin
          step[c] = enc_step(rise_a[c], lvl_b[c] ^ swp)
            + enc_step(rise_b[c], lvl_a[c] ^ swp);
        end
      endcase
      if ((pm == PROG_INHIBIT) & pg) begin
        step[c] = 3'sd0;
      end
    end
  end

  // Next count; a clear wins over a step in the same cycle
  logic [31:0] count_nxt [NCH];
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (clear_now[c]) begin
        count_nxt[c] = 32'h0000_0000;
      end else begin
        count_nxt[c] = count_r[c] + {{29{step[c][2]}}, step[c]};
      end
    end
  end

  // Bus decode; channel blocks sit above the common registers
  logic acc;
  logic wr_now;
  logic [1:0] ch_sel;
  logic ch_hit;
  logic [4:0] ch_off;
  assign acc = cyc_i & stb_i & (bus_r == BUS_IDLE);
  // Writes land at the edge on which the master samples ack
  assign wr_now = cyc_i & stb_i & we_i & (bus_r == BUS_ACK);
  assign ch_hit = adr_i >= `PC_OFF_CH_BASE;
  assign ch_sel = 2'((adr_i - `PC_OFF_CH_BASE) >> `PC_CH_STRIDE_LOG2);
  assign ch_off = adr_i[4:0];

  // Registered ack, then two cycles before the next request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_r <= BUS_IDLE;
      ack_o <= 1'b0;
    end else begin
      unique case (bus_r)
        BUS_IDLE: begin
          ack_o <= acc;
          if (acc) begin
            bus_r <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          ack_o <= 1'b0;
          bus_r <= BUS_GAP;
        end
        BUS_GAP: bus_r <= BUS_IDLE;
        default: bus_r <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (acc) begin
      // Writes and unmapped reads answer zero
      dat_o <= 32'h0000_0000;
      if (!we_i && ch_hit) begin
        unique case (ch_off)
          `PC_OFF_CH_CTRL: dat_o <= ctrl_r[ch_sel];
          `PC_OFF_CH_COUNT: dat_o <= count_r[ch_sel];
          `PC_OFF_CH_LOW: dat_o <= low_r[ch_sel];
          `PC_OFF_CH_HIGH: dat_o <= high_r[ch_sel];
          default: dat_o <= 32'h0000_0000;
        endcase
      end else if (!we_i) begin
        unique case (adr_i)
          `PC_OFF_STATUS: dat_o <= {24'h000000, status_r};
          `PC_OFF_IRQ_EN: dat_o <= {24'h000000, irq_en_r};
          `PC_OFF_LEVELS: dat_o <= {24'h000000, over_limit_flag_o, under_limit_flag_o};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Channel configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_r[c] <= `PC_CTRL_RESET;
        low_r[c] <= `PC_LOW_RESET;
        high_r[c] <= `PC_HIGH_RESET;
      end
    end else if (wr_now && ch_hit) begin
      if (ch_off == `PC_OFF_CH_CTRL) begin
        ctrl_r[ch_sel] <= merge(ctrl_r[ch_sel], dat_i, sel_i);
      end
      if (ch_off == `PC_OFF_CH_LOW) begin
        low_r[ch_sel] <= merge(low_r[ch_sel], dat_i, sel_i);
      end
      if (ch_off == `PC_OFF_CH_HIGH) begin
        high_r[ch_sel] <= merge(high_r[ch_sel], dat_i, sel_i);
      end
    end
  end

  // Manual clear strobe lasts one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_clear_r <= 4'h0;
    end else if (wr_now && adr_i == `PC_OFF_CLEAR && sel_i[0]) begin
      sw_clear_r <= dat_i[3:0];
    end else begin
      sw_clear_r <= 4'h0;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_r <= 8'h00;
    end else if (wr_now && adr_i == `PC_OFF_IRQ_EN && sel_i[0]) begin
      irq_en_r <= dat_i[7:0];
    end
  end

  // Count registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        count_r[c] <= 32'h0000_0000;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        count_r[c] <= count_nxt[c];
      end
    end
  end

  // Limit comparisons on the next count, signed
  logic [3:0] under_nxt;
  logic [3:0] over_nxt;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      under_nxt[c] = $signed(count_nxt[c]) < $signed(low_r[c]);
      over_nxt[c] = $signed(count_nxt[c]) > $signed(high_r[c]);
    end
  end

  // Status bits latch on entering a limit; entering beats a clear
  logic [7:0] irq_clr;
  logic [7:0] status_nxt;
  always_comb begin
    irq_clr = 8'h00;
    if (wr_now && adr_i == `PC_OFF_IRQ_CLR && sel_i[0]) begin
      irq_clr = dat_i[7:0];
    end
    status_nxt = (status_r & ~irq_clr) | {over_nxt & ~over_limit_flag_o,
                                          under_nxt & ~under_limit_flag_o};
  end

  // Flags are registered copies of the comparisons
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      under_limit_flag_o <= 4'h0;
      over_limit_flag_o <= 4'h0;
    end else begin
      under_limit_flag_o <= under_nxt;
      over_limit_flag_o <= over_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= 8'h00;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Interrupt level follows enabled status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_nxt & irq_en_r);
    end
  end
endmodule // pulse_counter

// File: tb/pulse_counter_assertions.sv
/* Port checker of the pulse counter's bus answer, reset state and flags.
 Assumes it is bound to pulse_counter and sees only its ports. */
`timescale 1ns/100ps
module pulse_counter_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [3:0] under_limit_flag_o,
  input wire logic [3:0] over_limit_flag_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  sequence s_gap;
    !ack_o ##1 !ack_o;
  endsequence
  property p_pulse;
    disable iff (rst_i) ack_o |=> s_gap;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_answer;
    disable iff (rst_i) $rose(cyc_i && stb_i) |-> ##[1:3] ack_o;
  endproperty
  a_answer: assert property (p_answer) else $error("no ack");
  property p_cause;
    disable iff (rst_i) ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_cause: assert property (p_cause) else $error("ack unasked");
  property p_wdat;
    disable iff (rst_i) ack_o && $past(we_i) |-> dat_o == 32'h0;
  endproperty
  a_wdat: assert property (p_wdat) else $error("write data out");
  property p_rst_bus;
    rst_i |=> !ack_o && dat_o == 32'h0;
  endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus reset");
  property p_rst_under;
    rst_i |=> under_limit_flag_o == 4'h0;
  endproperty
  a_rst_under: assert property (p_rst_under) else $error("under reset");
  property p_rst_over;
    rst_i |=> over_limit_flag_o == 4'h0;
  endproperty
  a_rst_over: assert property (p_rst_over) else $error("over reset");
  property p_rst_irq;
    rst_i |=> !irq_o;
  endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq reset");
endmodule // pulse_counter_assertions

// File: tb/field_pulse_model.sv
/* Field pulse source: contact or encoder outputs feeding counters 0..3.
 Assumes the bench paces it from the counter clock. */
`timescale 1ns/100ps
module field_pulse_model (
  input wire logic clk_i,
  output logic [3:0] a_o,
  output logic [3:0] b_o
);
  initial begin
    a_o = 4'h0;
    b_o = 4'h0;
  end
  // Contact closes for 4 cycles, opens for 4
  task automatic pulse(input logic sel_b, input int ch);
    repeat (2) begin
      @(posedge clk_i);
      if (sel_b)
        b_o[ch] <= ~b_o[ch];
      else
        a_o[ch] <= ~a_o[ch];
      repeat (3) @(posedge clk_i);
    end
  endtask
endmodule // field_pulse_model

// File: tb/universal_pulse_counter_test.sv
/* Self-checking bench of the pulse counter: modes, clears, limits, irq.
 Assumes the defines header and package are on the include path. */
`timescale 1ns/100ps
`include "pulse_counter_defs.svh"
module universal_pulse_counter_test;
  import pulse_counter_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i, prog_i, ext_clear_i, a, b, ul, ol;
  logic [31:0] dat_i, dat_o;
  logic [31:0] exp_q[$];
  int bad_count, checked;
  int base[4] = '{3, 1, -2, -3};
  pulse_counter i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .count_a_i(a), .count_b_i(b), .prog_i(prog_i), .ext_clear_i(ext_clear_i),
    .under_limit_flag_o(ul), .over_limit_flag_o(ol), .irq_o(irq_o));
  field_pulse_model i_src (.clk_i(clk_i), .a_o(a), .b_o(b));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic fail(input string m);
    bad_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic summarize();
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
    return `PC_OFF_CH_BASE + 8'(ch << `PC_CH_STRIDE_LOG2) + {3'h0, off};
  endfunction
  // One classic cycle; the expected read word is queued for the monitor
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, e);
    int n;
    n = 0;
    exp_q.push_back(w ? 32'h0 : e);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
    if (ack_o !== 1'b1)
      fail("no ack");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1) begin
      checked++;
      if (exp_q.size() == 0)
        fail("ack without request");
      else if (dat_o !== exp_q.pop_front())
        fail("read data");
    end
  end
  task automatic flag_chk(input logic ok, input string m);
    checked++;
    if (!ok)
      fail(m);
  endtask
  initial begin
    int ch, e;
    logic [1:0] m, p;
    {cyc_i, stb_i, we_i, adr_i, dat_i, prog_i, ext_clear_i} = '0;
    sel_i = 4'hf;
    rst_i = 1'b1;
    bad_count = 0;
    checked = 0;
    void'($urandom(55564));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ra(0, `PC_OFF_CH_HIGH), 0, 32'h7fffffff);
    wb(0, ra(0, `PC_OFF_CH_LOW), 0, 0);
    wb(0, 8'hfc, 0, 0);
    prog_i <= 4'hf;
    for (int k = 0; k < 12; k++) begin
      m = k[1:0];
      p = 2'(k / 4);
      ch = $urandom % 4;
      wb(1, ra(ch, `PC_OFF_CH_CTRL), {28'h0, p, m}, 0);
      wb(1, `PC_OFF_CLEAR, 32'(1 << ch), 0);
      wb(0, ra(ch, `PC_OFF_CH_COUNT), 0, 0);
      i_src.pulse(0, ch);
      i_src.pulse(1, ch);
      i_src.pulse(0, ch);
      repeat (8) @(posedge clk_i);
      e = (p == PROG_DIR && m != MODE_SUM) ? -base[m] : base[m];
      e = (p == PROG_INHIBIT) ? 0 : e;
      wb(0, ra(ch, `PC_OFF_CH_COUNT), 0, 32'(e));
    end
    wb(1, ra(0, `PC_OFF_CH_CTRL), 32'h20, 0);
    wb(1, ra(1, `PC_OFF_CH_CTRL), 32'h10, 0);
    wb(1, `PC_OFF_CLEAR, 32'h3, 0);
    ext_clear_i <= 4'h1;
    i_src.pulse(0, 0);
    ext_clear_i <= 4'h0;
    wb(0, ra(0, `PC_OFF_CH_COUNT), 0, 0);
    i_src.pulse(0, 0);
    i_src.pulse(0, 1);
    repeat (8) @(posedge clk_i);
    wb(0, ra(0, `PC_OFF_CH_COUNT), 0, 1);
    wb(0, ra(1, `PC_OFF_CH_COUNT), 0, 0);
    wb(1, `PC_OFF_CLEAR, 32'hf, 0);
    wb(1, `PC_OFF_IRQ_CLR, 32'hff, 0);
    wb(0, `PC_OFF_STATUS, 0, 0);
    wb(1, `PC_OFF_IRQ_EN, 32'h1, 0);
    wb(1, ra(0, `PC_OFF_CH_LOW), 32'h1, 0);
    repeat (2) @(posedge clk_i);
    flag_chk(ul === 4'h1 && irq_o === 1'b1, "under flag or irq");
    wb(1, `PC_OFF_IRQ_EN, 32'h0, 0);
    repeat (2) @(posedge clk_i);
    flag_chk(irq_o === 1'b0, "irq mask");
    wb(1, ra(1, `PC_OFF_CH_HIGH), 32'hffffffff, 0);
    repeat (2) @(posedge clk_i);
    flag_chk(ol === 4'h2, "over flag");
    wb(0, `PC_OFF_STATUS, 0, 32'h21);
    wb(1, `PC_OFF_IRQ_CLR, 32'h21, 0);
    wb(0, `PC_OFF_STATUS, 0, 0);
    summarize();
  end
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
endmodule // universal_pulse_counter_test
bind pulse_counter pulse_counter_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
  .under_limit_flag_o(under_limit_flag_o), .over_limit_flag_o(over_limit_flag_o),
  .irq_o(irq_o));
